// File: core/octal_drv_map.svh
`ifndef OCTAL_DRV_MAP_SVH
`define OCTAL_DRV_MAP_SVH

// ==========================================================
// register byte offsets
`define OCTAL_ADDR_STATUS 8'h00
`define OCTAL_ADDR_COMMAND 8'h04
`define OCTAL_ADDR_DIAG 8'h08
`define OCTAL_ADDR_CONTROL 8'h0C

// ==========================================================
// status field positions
`define OCTAL_STAT_FAULT 0
`define OCTAL_STAT_HOT 1
`define OCTAL_STAT_LOGIC 2
`define OCTAL_STAT_LOAD 3
`define OCTAL_STAT_SELECTED 4

// ==========================================================
// control field positions and reset values
`define OCTAL_CTRL_ENABLE 0
`define OCTAL_CTRL_RESET 1'h1
`define OCTAL_CMD_RESET 8'h00

`endif

// File: core/octal_drv_pkg.sv
package octal_drv_pkg;
  // ==========================================================
  // shared types
  typedef logic [7:0] chan_t;
  typedef logic [2:0] cnt_t;
  typedef enum logic [0:0] {FRAME_IDLE, FRAME_ACTIVE} frame_e;

  // ==========================================================
  // gray code helpers
  function automatic cnt_t bin2gray(input cnt_t b);
    return b ^ (b >> 1);
  endfunction : bin2gray

  function automatic cnt_t gray2bin(input cnt_t g);
    cnt_t b;
    b = g;
    for (int i = 1; i < 3; i++) begin
      b = b ^ (g >> i);
    end
    return b;
  endfunction : gray2bin
endpackage : octal_drv_pkg

// File: core/spi_link_if.sv
`timescale 1ns/1ps
// ==========================================================
// signals between core domain and serial clock domain
interface spi_link_if;
  logic link_rst_n;
  octal_drv_pkg::cnt_t count_gray;
  octal_drv_pkg::chan_t shift_word;
  modport link (input link_rst_n, output count_gray, output shift_word);
  modport core (output link_rst_n, input count_gray, input shift_word);
endinterface : spi_link_if

// File: core/spi_link.sv
`timescale 1ns/1ps
// ==========================================================
// serial clock domain: input shifter and pulse counter
module spi_link (
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic din_i,
  spi_link_if.link lnk
);
  import octal_drv_pkg::*;

  chan_t word_reg;
  chan_t word_next;
  cnt_t cnt_reg;
  cnt_t cnt_next;
  cnt_t gray_reg;
  cnt_t gray_next;

  // shift only while selected, first bit ends in bit 0
  always_comb begin
    word_next = word_reg;
    cnt_next = cnt_reg;
    if (!sel_n_i) begin
      word_next = {din_i, word_reg[7:1]};
      cnt_next = cnt_t'(cnt_reg + 3'h1);
    end
    gray_next = bin2gray(cnt_next);
  end

  // registers on rising serial clock
  always_ff @(posedge sclk_i or negedge lnk.link_rst_n) begin
    if (!lnk.link_rst_n) begin
      word_reg <= 8'h00;
      cnt_reg <= 3'h0;
      gray_reg <= 3'h0;
    end else begin
      word_reg <= word_next;
      cnt_reg <= cnt_next;
      gray_reg <= gray_next;
    end
  end

  assign lnk.count_gray = gray_reg;
  assign lnk.shift_word = word_reg;
endmodule : spi_link

// File: core/octal_drv.sv
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "octal_drv_map.svh"
// ==========================================================
// eight channel high side switch control with serial slave
module octal_drv (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // serial link, clock and select from the host
  input wire logic SCLK_I,
  input wire logic SEL_N_I,
  input wire logic DIN_I,
  output logic DOUT_O,
  output logic DOUT_OE_O,
  // analog side
  input wire octal_drv_pkg::chan_t OUTPUT_SENSE_BIT_I,
  input wire logic THERMAL_SHUTDOWN_I,
  input wire logic LOGIC_SUPPLY_I,
  input wire logic LOAD_SUPPLY_I,
  output octal_drv_pkg::chan_t DRIVE_O
);
  import octal_drv_pkg::*;

  localparam int NIN = 12;

  // ==========================================================
  // link domain instance
  spi_link_if lnk ();

  spi_link u_link (
    .sclk_i(SCLK_I),
    .sel_n_i(SEL_N_I),
    .din_i(DIN_I),
    .lnk(lnk)
  );

  // ==========================================================
  // pin synchronisers, three stages, agreement filter
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  logic [NIN-1:0] s3_reg;
  logic [NIN-1:0] filt_reg;
  logic [NIN-1:0] filt_next;

  function automatic logic [NIN-1:0] agree(input logic [NIN-1:0] a, input logic [NIN-1:0] b,
                                           input logic [NIN-1:0] keep);
    return (a & b) | (keep & (a ^ b));
  endfunction : agree

  // filter takes a new level once stages two and three match
  always_comb begin
    raw = {SEL_N_I, LOAD_SUPPLY_I, LOGIC_SUPPLY_I, THERMAL_SHUTDOWN_I, OUTPUT_SENSE_BIT_I};
    filt_next = agree(s2_reg, s3_reg, filt_reg);
  end

  // synchroniser registers, select idles high
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s1_reg <= 12'h800;
      s2_reg <= 12'h800;
      s3_reg <= 12'h800;
      filt_reg <= 12'h800;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  chan_t sense;
  logic hot;
  logic logic_ok;
  logic load_ok;
  logic sel_n;

  assign sense = filt_reg[7:0];
  assign hot = filt_reg[8];
  assign logic_ok = filt_reg[9];
  assign load_ok = filt_reg[10];
  assign sel_n = filt_reg[11];

  // ==========================================================
  // crossing of pulse count (gray, two flops) and shift word
  cnt_t g1_reg;
  cnt_t g2_reg;
  chan_t w1_reg;
  chan_t w2_reg;
  logic link_rst_n_reg;

  // word only changes while selected, read after select rise
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      g1_reg <= 3'h0;
      g2_reg <= 3'h0;
      w1_reg <= 8'h00;
      w2_reg <= 8'h00;
      link_rst_n_reg <= 1'b0;
    end else begin
      g1_reg <= lnk.count_gray;
      g2_reg <= g1_reg;
      w1_reg <= lnk.shift_word;
      w2_reg <= w1_reg;
      link_rst_n_reg <= 1'b1;
    end
  end

  assign lnk.link_rst_n = link_rst_n_reg;

  // ==========================================================
  // frame tracking, command, fault, diagnostics
  frame_e frame_reg;
  frame_e frame_next;
  cnt_t start_reg;
  cnt_t start_next;
  chan_t cmd_reg;
  chan_t cmd_next;
  chan_t diag_reg;
  chan_t diag_next;
  chan_t snap_reg;
  chan_t snap_next;
  logic fault_reg;
  logic fault_next;
  logic enable_reg;
  logic enable_next;
  chan_t drive_reg;
  chan_t drive_next;
  logic dout_reg;
  logic dout_next;
  logic dout_oe_reg;
  logic dout_oe_next;
  cnt_t count_now;
  cnt_t pulses;

  // frame edges come from the filtered select; the device never starts a frame
  always_comb begin
    count_now = gray2bin(g2_reg);
    pulses = cnt_t'(count_now - start_reg);
    frame_next = frame_reg;
    start_next = start_reg;
    cmd_next = cmd_reg;
    snap_next = snap_reg;
    fault_next = fault_reg;
    // diagnostic register: sensed level per output, faults forced
    diag_next = fault_reg ? ~cmd_reg : sense;
    case (frame_reg)
      FRAME_IDLE: begin
        if (!sel_n) begin
          frame_next = FRAME_ACTIVE;
          start_next = count_now;
          snap_next = diag_reg;
        end
      end
      FRAME_ACTIVE: begin
        if (sel_n) begin
          frame_next = FRAME_IDLE;
          cmd_next = w2_reg;
          snap_next = diag_reg;
          if (!hot && pulses == 3'h0) begin
            fault_next = 1'b0;
          end
        end
      end
      default: begin
        frame_next = FRAME_IDLE;
      end
    endcase
    // a hot die wins over any clearing transfer
    if (hot) begin
      fault_next = 1'b1;
    end
  end

  // frame, command, diagnostic and fault registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      frame_reg <= FRAME_IDLE;
      start_reg <= 3'h0;
      cmd_reg <= `OCTAL_CMD_RESET;
      diag_reg <= 8'h00;
      snap_reg <= 8'h00;
      fault_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      start_reg <= start_next;
      cmd_reg <= cmd_next;
      diag_reg <= diag_next;
      snap_reg <= snap_next;
      fault_reg <= fault_next;
    end
  end

  // ==========================================================
  // driver outputs, gated by fault, supplies and enable
  always_comb begin
    // all drivers follow the command together, one cycle later through the driver register
    if (fault_reg || !logic_ok || !load_ok || !enable_reg) begin
      drive_next = 8'h00;
    end else begin
      drive_next = cmd_reg;
    end
  end

  // driver register, command itself is kept while gated
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      drive_reg <= 8'h00;
    end else begin
      drive_reg <= drive_next;
    end
  end

  // ==========================================================
  // serial output bit, picked by pulses seen in this frame
  always_comb begin
    dout_oe_next = (frame_reg == FRAME_ACTIVE);
    dout_next = dout_oe_next ? snap_reg[pulses] : 1'b0;
  end

  // serial output registers, enable high while the pin is driven
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      dout_reg <= 1'b0;
      dout_oe_reg <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      dout_oe_reg <= dout_oe_next;
    end
  end

  // ==========================================================
  // wishbone slave, ack one cycle after request
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic req;

  // decode and read mux; unmapped reads zero, writes ignored
  always_comb begin
    req = CYC_I && STB_I && !ack_reg;
    ack_next = req;
    dat_next = dat_reg;
    enable_next = enable_reg;
    if (req) begin
      dat_next = 32'h0000_0000;
      case (ADR_I)
        `OCTAL_ADDR_STATUS: begin
          dat_next[`OCTAL_STAT_FAULT] = fault_reg;
          dat_next[`OCTAL_STAT_HOT] = hot;
          dat_next[`OCTAL_STAT_LOGIC] = logic_ok;
          dat_next[`OCTAL_STAT_LOAD] = load_ok;
          dat_next[`OCTAL_STAT_SELECTED] = (frame_reg == FRAME_ACTIVE);
        end
        `OCTAL_ADDR_COMMAND: begin
          dat_next[7:0] = cmd_reg;
        end
        `OCTAL_ADDR_DIAG: begin
          dat_next[7:0] = diag_reg;
        end
        `OCTAL_ADDR_CONTROL: begin
          dat_next[`OCTAL_CTRL_ENABLE] = enable_reg;
          if (WE_I && SEL_I[0]) begin
            enable_next = DAT_I[`OCTAL_CTRL_ENABLE];
          end
        end
        default: begin
          dat_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      enable_reg <= `OCTAL_CTRL_RESET;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      enable_reg <= enable_next;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;
  assign DOUT_O = dout_reg;
  assign DOUT_OE_O = dout_oe_reg;
  assign DRIVE_O = drive_reg;
endmodule : octal_drv

// File: sim/octal_drv_asserts.sv
`timescale 1ns/1ps
// ======
// port checks of the switch controller
module octal_drv_asserts (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic [31:0] DAT_O,
  input wire logic SEL_N_I,
  input wire logic DOUT_OE_O,
  input wire logic THERMAL_SHUTDOWN_I,
  input wire logic LOGIC_SUPPLY_I,
  input wire logic LOAD_SUPPLY_I,
  input wire octal_drv_pkg::chan_t DRIVE_O
);
  import octal_drv_pkg::*;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // bus answers
  ack_timing_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acked");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  dat_hold_a: assert property (!$stable(DAT_O) |-> ACK_O)
    else $error("read data moved");
  // drivers and serial output
  supply_off_a: assert property ((!LOGIC_SUPPLY_I || !LOAD_SUPPLY_I) [*8] |-> DRIVE_O == 8'h00)
    else $error("driver on without supply");
  thermal_off_a: assert property (THERMAL_SHUTDOWN_I [*8] |-> DRIVE_O == 8'h00)
    else $error("driver on while hot");
  oe_idle_a: assert property (SEL_N_I [*8] |-> !DOUT_OE_O)
    else $error("output driven while idle");
  oe_active_a: assert property (!SEL_N_I [*8] |-> DOUT_OE_O)
    else $error("output not driven in frame");
  drive_hold_a: assert property ((!SEL_N_I && !CYC_I && LOGIC_SUPPLY_I && LOAD_SUPPLY_I
    && !THERMAL_SHUTDOWN_I) [*8] |=> $stable(DRIVE_O))
    else $error("drivers moved in frame");
endmodule : octal_drv_asserts
bind octal_drv octal_drv_asserts watch (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .ACK_O(ACK_O), .DAT_O(DAT_O), .SEL_N_I(SEL_N_I), .DOUT_OE_O(DOUT_OE_O),
  .THERMAL_SHUTDOWN_I(THERMAL_SHUTDOWN_I), .LOGIC_SUPPLY_I(LOGIC_SUPPLY_I),
  .LOAD_SUPPLY_I(LOAD_SUPPLY_I), .DRIVE_O(DRIVE_O));

// File: sim/spi_host_model.sv
`timescale 1ns/1ps
// ======
// serial master, clock idles high
module spi_host_model (
  output logic sclk_o,
  output logic sel_n_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  // idle: select and clock high
  initial begin
    sclk_o = 1'b1;
    sel_n_o = 1'b1;
    din_o = 1'b0;
  end
  // one pulse, data flips once hold is over
  task automatic pulse(input logic b);
    sclk_o = 1'b0;
    din_o = b;
    #7.5;
    sclk_o = 1'b1;
    #20;
    din_o = ~b;
    #180;
  endtask : pulse
  // frame of n pulses, channel 1 first
  task automatic xfer(input logic [15:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    sel_n_o = 1'b0;
    #3000;
    for (int i = 0; i < n; i++) begin
      rx = {dout_oe_i ? dout_i : ~dout_i, rx[7:1]}; // released pin reads inverted
      pulse(tx[i]);
    end
    #1000;
    sel_n_o = 1'b1;
    #400; // settling gap before the next reading
  endtask : xfer
  // clocking with select high
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      pulse(i[0]);
    end
  endtask : noise
endmodule : spi_host_model

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "octal_drv_map.svh"
// ======
// switch controller bench
module testbench;
  import octal_drv_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, hot = 1'b0, lsup = 1'b1, vsup = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [3:0] bsel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  chan_t sense = 8'hA5, drive, rx;
  logic ack, sclk, sel_n, din, dout, dout_oe;
  int miscompares = 0, comparisons = 0;
  // system clock
  always #10 clk = ~clk;
  octal_drv dut (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(bsel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .SCLK_I(sclk), .SEL_N_I(sel_n), .DIN_I(din),
    .DOUT_O(dout), .DOUT_OE_O(dout_oe), .OUTPUT_SENSE_BIT_I(sense), .THERMAL_SHUTDOWN_I(hot),
    .LOGIC_SUPPLY_I(lsup), .LOAD_SUPPLY_I(vsup), .DRIVE_O(drive));
  spi_host_model host (.sclk_o(sclk), .sel_n_o(sel_n), .din_o(din), .dout_i(dout), .dout_oe_i(dout_oe));
  // compare and count
  task automatic chk(input chan_t got, input chan_t exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  // one classic bus cycle, result in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // ack sampled at each rising edge while the request stands
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (ack !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // frame, then check the drivers
  task automatic fr(input logic [15:0] tx, input int n, input chan_t exp);
    @(posedge clk);
    #3;
    host.xfer(tx, n, rx);
    chk(drive, exp);
  endtask : fr
  task automatic t_regs();
    wb(1'b0, `OCTAL_ADDR_CONTROL, 32'h0);
    chk(q[7:0], 8'h01);
    wb(1'b0, `OCTAL_ADDR_STATUS, 32'h0);
    chk(q[7:0], 8'h0C);
    chk(q[31:24] | q[23:16] | q[15:8], 8'h00);
    wb(1'b1, `OCTAL_ADDR_COMMAND, 32'hFF);
    wb(1'b0, `OCTAL_ADDR_COMMAND, 32'h0);
    chk(q[7:0], 8'h00);
    wb(1'b0, 8'h40, 32'h0);
    chk(q[7:0], 8'h00);
    $display("regs test done");
  endtask : t_regs
  task automatic t_frames();
    fr(16'h003C, 8, 8'h3C);
    chk(rx, 8'hA5);
    @(posedge clk);
    sense <= 8'h0F;
    fr(16'h81FF, 16, 8'h81);
    chk(rx, 8'h0F);
    wb(1'b0, `OCTAL_ADDR_DIAG, 32'h0);
    chk(q[7:0], 8'h0F);
    fr(16'h00C3, 8, 8'hC3);
    wb(1'b0, `OCTAL_ADDR_COMMAND, 32'h0);
    chk(q[7:0], 8'hC3);
    $display("frames test done");
  endtask : t_frames
  task automatic t_supply();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      lsup <= i[0];
      vsup <= ~i[0];
      settle(10);
      chk(drive, 8'h00);
      @(posedge clk);
      lsup <= 1'b1;
      vsup <= 1'b1;
      settle(10);
      chk(drive, 8'hC3);
    end
    wb(1'b1, `OCTAL_ADDR_CONTROL, 32'h0);
    settle(2);
    chk(drive, 8'h00);
    wb(1'b1, `OCTAL_ADDR_CONTROL, 32'h1);
    settle(2);
    chk(drive, 8'hC3);
    // control write without its byte lane is ignored
    @(posedge clk);
    bsel <= 4'hE;
    wb(1'b1, `OCTAL_ADDR_CONTROL, 32'h0);
    settle(2);
    chk(drive, 8'hC3);
    @(posedge clk);
    bsel <= 4'hF;
    $display("supply test done");
  endtask : t_supply
  task automatic t_thermal();
    @(posedge clk);
    hot <= 1'b1;
    settle(10);
    chk(drive, 8'h00);
    fr(16'h00C3, 8, 8'h00);
    chk(rx, 8'h3C);
    chk(rx ^ 8'hC3, 8'hFF);
    wb(1'b0, `OCTAL_ADDR_DIAG, 32'h0);
    chk(q[7:0], 8'h3C);
    @(posedge clk);
    hot <= 1'b0;
    fr(16'h00C3, 7, 8'h00);
    wb(1'b0, `OCTAL_ADDR_STATUS, 32'h0);
    chk(q[7:0], 8'h0D);
    fr(16'h00C3, 8, 8'hC3);
    $display("thermal test done");
  endtask : t_thermal
  task automatic t_ignore();
    host.noise();
    settle(10);
    chk(drive, 8'hC3);
    // status read while the frame is open shows it selected
    fork
      host.xfer(16'h0081, 8, rx);
      begin
        settle(40);
        wb(1'b0, `OCTAL_ADDR_STATUS, 32'h0);
      end
    join
    chk(q[7:0], 8'h1C);
    chk(drive, 8'h81);
    chk(rx, 8'h0F);
    $display("ignore test done");
  endtask : t_ignore
  // reset in mid run, then a fresh frame
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    settle(3);
    chk(drive, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    settle(12);
    wb(1'b0, `OCTAL_ADDR_COMMAND, 32'h0);
    chk(q[7:0], 8'h00);
    wb(1'b0, `OCTAL_ADDR_CONTROL, 32'h0);
    chk(q[7:0], 8'h01);
    fr(16'h0024, 8, 8'h24);
    $display("reset test done");
  endtask : t_reset
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    settle(12);
    t_regs();
    t_frames();
    t_supply();
    t_thermal();
    t_ignore();
    t_reset();
    print_verdict();
  end
  // hang guard
  initial begin
    #500000;
    miscompares++;
    print_verdict();
  end
endmodule : testbench
